// ==== hw/ufc_pkg.sv ====
// Shared constants, field layout and carrier types for the UART FIFO control block
package ufc_pkg;

  // Channel count and FIFO geometry
  localparam int NUM_CHAN = 2;
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam int DATA_W = 8;

  // Register byte offsets inside one channel window
  localparam logic [4:0] REG_DATA_OFF = 5'h00;
  localparam logic [4:0] REG_CTRL_OFF = 5'h04;
  localparam logic [4:0] REG_STAT_OFF = 5'h08;
  // Address bit that selects the channel window (stride 0x20)
  localparam int CHAN_SEL_BIT = 5;

  // Control register field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RXFL_BIT = 1;
  localparam int CTRL_TXFL_BIT = 2;
  localparam int CTRL_MODE_BIT = 3;
  localparam int CTRL_TRIG_LSB = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status register field positions
  localparam int STAT_TXCNT_LSB = 0;
  localparam int STAT_RXCNT_LSB = 8;
  localparam int STAT_IRQ_BIT = 16;
  localparam int STAT_TXREQ_BIT = 17;
  localparam int STAT_RXREQ_BIT = 18;
  localparam int STAT_OVR_BIT = 19;

  // Receive trigger levels for field codes 00, 01, 10, 11
  localparam logic [CNT_W-1:0] TRIG_LVL0 = 5'h01;
  localparam logic [CNT_W-1:0] TRIG_LVL1 = 5'h04;
  localparam logic [CNT_W-1:0] TRIG_LVL2 = 5'h08;
  localparam logic [CNT_W-1:0] TRIG_LVL3 = 5'h0E;
  // Capacity with FIFOs on (16 entries) and when FIFOs are off: a single holding register
  localparam logic [CNT_W-1:0] CAP_FIFO = 5'h10;
  localparam logic [CNT_W-1:0] CAP_SINGLE = 5'h01;

  // Stored control fields of one channel
  typedef struct packed {
    logic [1:0] trig;
    logic dma_mode;
    logic fifo_en;
  } ufc_ctrl_type;

  // Captured AHB address phase
  typedef struct packed {
    logic mapped;
    logic chan;
    logic [4:0] off;
  } ufc_aph_type;

  // Bus slave states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRITE = 2'b01,
    ST_RD_WAIT = 2'b10,
    ST_RD_DONE = 2'b11
  } ufc_state_type;

endpackage

// ==== hw/ufc_mem.sv ====
// Small character store with registered read data
`timescale 1ns/100ps
module ufc_mem
  import ufc_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int AW = PTR_W
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] store [DEPTH];

  // Array has no reset; contents are only read behind a valid count
  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      store[wr_addr] <= wr_data;
    end
  end

  // Read data registered, one cycle behind the address
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_data <= '0;
    end
    else
    begin
      rd_data <= store[rd_addr];
    end
  end

endmodule

// ==== hw/ufc_top.sv ====
// Dual-channel UART FIFO control, DMA ready outputs and AHB-Lite register slave
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
module ufc_top
  import ufc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Transmit shifter side, per channel
  input wire logic [NUM_CHAN-1:0] tx_pop,
  output logic [NUM_CHAN-1:0] tx_valid,
  output logic [NUM_CHAN-1:0][DATA_W-1:0] tx_data,
  // Receive shifter side, per channel
  input wire logic [NUM_CHAN-1:0] rx_push,
  input wire logic [NUM_CHAN-1:0][DATA_W-1:0] rx_data,
  input wire logic [NUM_CHAN-1:0] rx_timeout,
  // DMA requests and receive interrupt, per channel
  output logic [NUM_CHAN-1:0] tx_dma_request_n,
  output logic [NUM_CHAN-1:0] rx_dma_request_n,
  output logic [NUM_CHAN-1:0] rx_data_irq
);

  // Bus slave state
  ufc_state_type state_reg;
  ufc_state_type state_next;
  ufc_aph_type aph_reg;
  logic [31:0] rdata_next;
  logic accept;

  // Per-channel state, visible to the read mux
  ufc_ctrl_type ctrl_reg [NUM_CHAN];
  logic [NUM_CHAN-1:0] tx_queue_flush;
  logic [NUM_CHAN-1:0] rx_queue_flush;
  logic [CNT_W-1:0] tx_cnt [NUM_CHAN];
  logic [CNT_W-1:0] rx_cnt [NUM_CHAN];
  logic [DATA_W-1:0] rx_q [NUM_CHAN];
  logic [NUM_CHAN-1:0] rx_q_ok;
  logic [NUM_CHAN-1:0] ovr_reg;
  logic [NUM_CHAN-1:0] rx_act_reg;

  // Trigger field decode
  function automatic logic [CNT_W-1:0] trig_level(input logic [1:0] code);
    logic [CNT_W-1:0] lvl;
    unique case (code)
      2'b00: lvl = TRIG_LVL0;
      2'b01: lvl = TRIG_LVL1;
      2'b10: lvl = TRIG_LVL2;
      2'b11: lvl = TRIG_LVL3;
    endcase
    return lvl;
  endfunction

  // Address phase taken on any nonsequential or sequential transfer
  assign accept = hsel && htrans[1] && hready;
  assign hresp = 1'b0;
  // Reads insert one wait state so the registered store output is current
  assign hreadyout = (state_reg != ST_RD_WAIT);

  // Slave sequencing
  always_comb
  begin
    state_next = ST_IDLE;
    if (state_reg == ST_RD_WAIT)
    begin
      state_next = ST_RD_DONE;
    end
    else if (accept)
    begin
      state_next = hwrite ? ST_WRITE : ST_RD_WAIT;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Address phase capture; only the two channel windows are mapped
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aph_reg <= '0;
    end
    else if (accept && state_reg != ST_RD_WAIT)
    begin
      aph_reg.mapped <= (haddr[31:CHAN_SEL_BIT+1] == '0) && (haddr[1:0] == 2'b00)
        && (haddr[4:0] == REG_DATA_OFF || haddr[4:0] == REG_CTRL_OFF
        || haddr[4:0] == REG_STAT_OFF);
      aph_reg.chan <= haddr[CHAN_SEL_BIT];
      aph_reg.off <= haddr[4:0];
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (aph_reg.mapped)
    begin
      unique case (aph_reg.off)
        REG_DATA_OFF:
        begin
          if (rx_q_ok[aph_reg.chan])
          begin
            rdata_next[DATA_W-1:0] = rx_q[aph_reg.chan];
          end
        end
        REG_CTRL_OFF:
        begin
          // Bits 5:4 always read zero
          rdata_next[CTRL_TRIG_LSB+:2] = ctrl_reg[aph_reg.chan].trig;
          rdata_next[CTRL_MODE_BIT] = ctrl_reg[aph_reg.chan].dma_mode;
          rdata_next[CTRL_TXFL_BIT] = tx_queue_flush[aph_reg.chan];
          rdata_next[CTRL_RXFL_BIT] = rx_queue_flush[aph_reg.chan];
          rdata_next[CTRL_EN_BIT] = ctrl_reg[aph_reg.chan].fifo_en;
        end
        REG_STAT_OFF:
        begin
          rdata_next[STAT_TXCNT_LSB+:CNT_W] = tx_cnt[aph_reg.chan];
          rdata_next[STAT_RXCNT_LSB+:CNT_W] = rx_cnt[aph_reg.chan];
          rdata_next[STAT_IRQ_BIT] = rx_data_irq[aph_reg.chan];
          rdata_next[STAT_TXREQ_BIT] = tx_dma_request_n[aph_reg.chan];
          rdata_next[STAT_RXREQ_BIT] = rx_dma_request_n[aph_reg.chan];
          rdata_next[STAT_OVR_BIT] = ovr_reg[aph_reg.chan];
        end
        default:
        begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // Read data held from the wait cycle through the end of the data phase
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (state_reg == ST_RD_WAIT)
    begin
      hrdata <= rdata_next;
    end
  end

  // One independent slice per channel
  for (genvar c = 0; c < NUM_CHAN; c++)
  begin : g_chan
    logic sel;
    logic data_wr;
    logic ctrl_wr;
    logic data_rd;
    logic stat_rd;
    logic [CNT_W-1:0] cap;
    logic [PTR_W-1:0] tx_wp;
    logic [PTR_W-1:0] tx_rp;
    logic [PTR_W-1:0] rx_wp;
    logic [PTR_W-1:0] rx_rp;
    logic tx_push;
    logic tx_take;
    logic rx_put;
    logic rx_take;
    logic mode1;
    logic [CNT_W-1:0] level;

    // Per-channel decode of the bus access in its data phase
    assign sel = aph_reg.mapped && (aph_reg.chan == 1'(c));
    assign data_wr = (state_reg == ST_WRITE) && sel && aph_reg.off == REG_DATA_OFF;
    assign ctrl_wr = (state_reg == ST_WRITE) && sel && aph_reg.off == REG_CTRL_OFF;
    assign data_rd = (state_reg == ST_RD_WAIT) && sel && aph_reg.off == REG_DATA_OFF;
    assign stat_rd = (state_reg == ST_RD_WAIT) && sel && aph_reg.off == REG_STAT_OFF;

    // Disabled FIFOs shrink to a single holding register
    assign cap = ctrl_reg[c].fifo_en ? CAP_FIFO : CAP_SINGLE;
    assign mode1 = ctrl_reg[c].fifo_en && ctrl_reg[c].dma_mode;
    assign level = trig_level(ctrl_reg[c].trig);

    // Pushes beyond capacity are dropped; pops need a current store output
    assign tx_push = data_wr && (tx_cnt[c] < cap) && !tx_queue_flush[c];
    assign tx_take = tx_pop[c] && tx_valid[c] && !tx_queue_flush[c];
    assign rx_put = rx_push[c] && (rx_cnt[c] < cap) && !rx_queue_flush[c];
    assign rx_take = data_rd && rx_q_ok[c] && !rx_queue_flush[c];

    // Control register; a write with enable low leaves the other fields alone
    always_ff @(posedge core_clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        ctrl_reg[c] <= ufc_ctrl_type'({CTRL_RESET[7:6], CTRL_RESET[3], CTRL_RESET[0]});
      end
      else if (ctrl_wr)
      begin
        ctrl_reg[c].fifo_en <= hwdata[CTRL_EN_BIT];
        if (hwdata[CTRL_EN_BIT])
        begin
          ctrl_reg[c].trig <= hwdata[CTRL_TRIG_LSB+:2];
          ctrl_reg[c].dma_mode <= hwdata[CTRL_MODE_BIT];
        end
      end
    end

    // Flush bits: set by a qualified write, cleared after the one flush cycle
    always_ff @(posedge core_clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        tx_queue_flush[c] <= CTRL_RESET[CTRL_TXFL_BIT];
        rx_queue_flush[c] <= CTRL_RESET[CTRL_RXFL_BIT];
      end
      else
      begin
        // Also flush when the enable bit toggles, so stale depth never leaks
        tx_queue_flush[c] <= ctrl_wr && ((hwdata[CTRL_EN_BIT] && hwdata[CTRL_TXFL_BIT])
          || hwdata[CTRL_EN_BIT] != ctrl_reg[c].fifo_en);
        rx_queue_flush[c] <= ctrl_wr && ((hwdata[CTRL_EN_BIT] && hwdata[CTRL_RXFL_BIT])
          || hwdata[CTRL_EN_BIT] != ctrl_reg[c].fifo_en);
      end
    end

    // Transmit pointers and count; a flush also drops tx_valid toward the external shifter
    always_ff @(posedge core_clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        tx_wp <= '0;
        tx_rp <= '0;
        tx_cnt[c] <= '0;
      end
      else if (tx_queue_flush[c])
      begin
        tx_wp <= '0;
        tx_rp <= '0;
        tx_cnt[c] <= '0;
      end
      else
      begin
        if (tx_push)
        begin
          tx_wp <= tx_wp + 1'b1;
        end
        if (tx_take)
        begin
          tx_rp <= tx_rp + 1'b1;
        end
        tx_cnt[c] <= tx_cnt[c] + CNT_W'(tx_push) - CNT_W'(tx_take);
      end
    end

    // Valid drops for a cycle after each pop while the store output settles
    always_ff @(posedge core_clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        tx_valid[c] <= 1'b0;
      end
      else
      begin
        tx_valid[c] <= (tx_cnt[c] != '0) && !tx_take && !tx_queue_flush[c];
      end
    end

    // Receive pointers and count
    always_ff @(posedge core_clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        rx_wp <= '0;
        rx_rp <= '0;
        rx_cnt[c] <= '0;
      end
      else if (rx_queue_flush[c])
      begin
        rx_wp <= '0;
        rx_rp <= '0;
        rx_cnt[c] <= '0;
      end
      else
      begin
        if (rx_put)
        begin
          rx_wp <= rx_wp + 1'b1;
        end
        if (rx_take)
        begin
          rx_rp <= rx_rp + 1'b1;
        end
        rx_cnt[c] <= rx_cnt[c] + CNT_W'(rx_put) - CNT_W'(rx_take);
      end
    end

    // Receive store output is trusted one cycle after the count settles
    always_ff @(posedge core_clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        rx_q_ok[c] <= 1'b0;
      end
      else
      begin
        rx_q_ok[c] <= (rx_cnt[c] != '0) && !rx_take && !rx_queue_flush[c];
      end
    end

    // Overrun sticky; a new overrun wins over the status read clear
    always_ff @(posedge core_clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        ovr_reg[c] <= 1'b0;
      end
      else if (rx_push[c] && !rx_put && !rx_queue_flush[c])
      begin
        ovr_reg[c] <= 1'b1;
      end
      else if (stat_rd)
      begin
        ovr_reg[c] <= 1'b0;
      end
    end

    // Block-mode receive request latch; set wins over the drained clear
    always_ff @(posedge core_clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        rx_act_reg[c] <= 1'b0;
      end
      else if (mode1 && rx_cnt[c] != '0 && (rx_cnt[c] >= level || rx_timeout[c]))
      begin
        rx_act_reg[c] <= 1'b1;
      end
      else if (!mode1 || rx_cnt[c] == '0)
      begin
        rx_act_reg[c] <= 1'b0;
      end
    end

    // Request pins and receive interrupt, registered
    always_ff @(posedge core_clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        tx_dma_request_n[c] <= 1'b0;
        rx_dma_request_n[c] <= 1'b1;
        rx_data_irq[c] <= 1'b0;
      end
      else
      begin
        if (mode1)
        begin
          tx_dma_request_n[c] <= (tx_cnt[c] == CAP_FIFO);
          rx_dma_request_n[c] <= !rx_act_reg[c];
        end
        else
        begin
          tx_dma_request_n[c] <= (tx_cnt[c] != '0);
          rx_dma_request_n[c] <= (rx_cnt[c] == '0);
        end
        // Level interrupt: on at the fill level, off once below it; with FIFOs off, on while a character is held
        if (ctrl_reg[c].fifo_en)
        begin
          rx_data_irq[c] <= (rx_cnt[c] >= level);
        end
        else
        begin
          rx_data_irq[c] <= (rx_cnt[c] != '0);
        end
      end
    end

    // Character stores for both directions
    ufc_mem u_tx_mem (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .wr_en(tx_push),
      .wr_addr(tx_wp),
      .wr_data(hwdata[DATA_W-1:0]),
      .rd_addr(tx_rp),
      .rd_data(tx_data[c])
    );

    ufc_mem u_rx_mem (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .wr_en(rx_put),
      .wr_addr(rx_wp),
      .wr_data(rx_data[c]),
      .rd_addr(rx_rp),
      .rd_data(rx_q[c])
    );
  end

  // Transfer size is fixed at a word; hsize is accepted but not checked
  logic unused_size;
  assign unused_size = ^hsize;

endmodule

// ==== sim/ufc_top_props.sv ====
// Concurrent checks on the FIFO control block ports
`timescale 1ns/100ps
module ufc_top_props
  import ufc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Shifter side, requests and interrupt
  input wire logic [NUM_CHAN-1:0] tx_pop,
  input wire logic [NUM_CHAN-1:0] tx_valid,
  input wire logic [NUM_CHAN-1:0] rx_push,
  input wire logic [NUM_CHAN-1:0] rx_timeout,
  input wire logic [NUM_CHAN-1:0] tx_dma_request_n,
  input wire logic [NUM_CHAN-1:0] rx_dma_request_n,
  input wire logic [NUM_CHAN-1:0] rx_data_irq
);
  logic rd_take;
  logic wr_take;
  logic [5:0] wr_hist_reg;
  logic [5:0] rx_hist_reg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Transfers taken by the slave
  assign rd_take = hsel & htrans[1] & hready & !hwrite;
  assign wr_take = hsel & htrans[1] & hready & hwrite;
  // Recent causes; deep enough for the three-edge mode 1 request path
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_hist_reg <= '0;
      rx_hist_reg <= '0;
    end
    else
    begin
      wr_hist_reg <= {wr_hist_reg[4:0], wr_take};
      rx_hist_reg <= {rx_hist_reg[4:0], rx_push[0] | rx_timeout[0]};
    end
  end
  okay_resp_a: assert property (hresp == 1'b0) else $error("response not OKAY");
  one_wait_a: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read wait state count wrong");
  wait_cause_a: assert property ($fell(hreadyout) |-> $past(rd_take))
    else $error("wait state without read");
  pop_drop_a: assert property (tx_pop[0] && tx_valid[0] |=> !tx_valid[0])
    else $error("tx valid held after pop");
  tx_req_cause_a: assert property ($rose(tx_dma_request_n[0]) |-> |wr_hist_reg)
    else $error("tx request released without write");
  rx_req_cause_a: assert property ($fell(rx_dma_request_n[0]) |-> |rx_hist_reg)
    else $error("rx request raised without character");
  irq_cause_a: assert property ($rose(rx_data_irq[0]) |-> |rx_hist_reg)
    else $error("interrupt without character");
  irq_req_a: assert property (rx_data_irq[0] && $past(rx_data_irq[0]) |-> !rx_dma_request_n[0])
    else $error("interrupt held without rx request");
endmodule

bind ufc_top ufc_top_props u_ufc_top_props (.core_clk(core_clk), .arst_n(arst_n),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .tx_pop(tx_pop), .tx_valid(tx_valid), .rx_push(rx_push),
  .rx_timeout(rx_timeout), .tx_dma_request_n(tx_dma_request_n),
  .rx_dma_request_n(rx_dma_request_n), .rx_data_irq(rx_data_irq));

// ==== sim/ufc_far_model.sv ====
// Shifter-side model: delivers received characters and takes transmit characters
`timescale 1ns/100ps
module ufc_far_model
  import ufc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Commands from the bench
  input wire logic [NUM_CHAN-1:0] push_go,
  input wire logic [NUM_CHAN-1:0] pop_go,
  // Block side
  input wire logic [NUM_CHAN-1:0] tx_valid,
  output logic [NUM_CHAN-1:0] tx_pop,
  output logic [NUM_CHAN-1:0] rx_push,
  output logic [NUM_CHAN-1:0][DATA_W-1:0] rx_data
);
  logic [DATA_W-1:0] seq_reg;
  // Take only an offered character, one pulse at a time
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_pop <= '0;
    end
    else
    begin
      tx_pop <= pop_go & tx_valid & ~tx_pop;
    end
  end
  // Idle data toggles so a stale character never looks fresh
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_push <= '0;
      rx_data <= '0;
      seq_reg <= 8'hA0;
    end
    else
    begin
      rx_push <= push_go;
      for (int c = 0; c < NUM_CHAN; c++)
      begin
        rx_data[c] <= push_go[c] ? seq_reg : ~rx_data[c];
      end
      if (|push_go)
      begin
        seq_reg <= seq_reg + 8'h01;
      end
    end
  end
endmodule

// ==== sim/uart_fifo_control_dma_ready_bench.sv ====
// Directed bench for the FIFO control block over its register bus
`timescale 1ns/100ps
module uart_fifo_control_dma_ready_bench;
  import ufc_pkg::*;
  logic core_clk;
  logic arst_n;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [NUM_CHAN-1:0] tx_pop, tx_valid, rx_push, rx_timeout;
  logic [NUM_CHAN-1:0] tx_dma_request_n, rx_dma_request_n, rx_data_irq;
  logic [NUM_CHAN-1:0][DATA_W-1:0] tx_data, rx_data;
  logic [NUM_CHAN-1:0] push_go, pop_go;
  logic [31:0] rd;
  int fails;
  int checked;
  int lvl;
  assign hready = hreadyout;
  ufc_top u_ufc_top (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_pop(tx_pop),
    .tx_valid(tx_valid), .tx_data(tx_data), .rx_push(rx_push), .rx_data(rx_data),
    .rx_timeout(rx_timeout), .tx_dma_request_n(tx_dma_request_n),
    .rx_dma_request_n(rx_dma_request_n), .rx_data_irq(rx_data_irq));
  ufc_far_model u_ufc_far_model (.core_clk(core_clk), .arst_n(arst_n), .push_go(push_go),
    .pop_go(pop_go), .tx_valid(tx_valid), .tx_pop(tx_pop), .rx_push(rx_push),
    .rx_data(rx_data));
  // 25 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One single AHB transfer; waits are sampled at the edge itself
  task automatic ahb(input logic wr_en, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr_en;
    @(posedge core_clk iff hreadyout === 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge core_clk iff hreadyout === 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(nm, exp, rd & m);
  endtask
  // Channel 0 receive characters, one per cycle
  task automatic push(input int n);
    push_go[0] <= 1'b1;
    wt(n);
    push_go[0] <= 1'b0;
    wt(6);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial
  begin
    wt(20000);
    fails++;
    end_of_test;
  end
  initial
  begin
    {hsel, haddr, htrans, hwrite, hwdata, push_go, pop_go, rx_timeout} = '0;
    hsize = 3'b010;
    fails = 0;
    checked = 0;
    arst_n = 1'b0;
    wt(10);
    arst_n <= 1'b1;
    wt(2);
    chk("tx_req_reset", 32'h0, tx_dma_request_n);
    chk("rx_req_reset", 32'h3, rx_dma_request_n);
    chk("irq_reset", 32'h0, rx_data_irq);
    rd_chk("ctrl_reset", 32'h04, 32'hFF, 32'h00);
    ahb(1'b1, 32'h40, 32'hFF);
    rd_chk("unmapped", 32'h40, 32'hFFFFFFFF, 32'h0);
    rd_chk("hole", 32'h0C, 32'hFFFFFFFF, 32'h0);
    // FIFOs off: single holding register
    ahb(1'b1, 32'h00, 32'h55);
    wt(3);
    chk("tx_req_loaded", 32'h1, tx_dma_request_n);
    chk("tx_char", 32'h55, tx_data[0]);
    pop_go[0] <= 1'b1;
    wt(4);
    pop_go[0] <= 1'b0;
    wt(3);
    chk("tx_req_empty", 32'h0, tx_dma_request_n);
    // FIFO mode 0 receive
    ahb(1'b1, 32'h04, 32'h01);
    push(1);
    chk("rx_req_data", 32'h2, rx_dma_request_n);
    chk("irq_one", 32'h1, rx_data_irq[0]);
    rd_chk("rx_char", 32'h00, 32'hFF, 32'hA0);
    wt(3);
    chk("rx_req_gone", 32'h3, rx_dma_request_n);
    // Mode 1 at every trigger code
    for (int k = 0; k < 4; k++)
    begin
      lvl = (k == 0) ? 1 : (k == 1) ? 4 : (k == 2) ? 8 : 14;
      ahb(1'b1, 32'h04, (k << 6) | 32'h09);
      if (lvl > 1)
        push(lvl - 1);
      chk("irq_below", 32'h0, rx_data_irq[0]);
      chk("rx_req_below", 32'h1, rx_dma_request_n[0]);
      push(1);
      chk("irq_at", 32'h1, rx_data_irq[0]);
      chk("rx_req_at", 32'h0, rx_dma_request_n[0]);
      if (lvl > 1)
      begin
        ahb(1'b0, 32'h00, 32'h0);
        wt(4);
        chk("rx_req_held", 32'h0, rx_dma_request_n[0]);
      end
      push(18 - lvl);
      rd_chk("rx_full", 32'h08, 32'h81F00, 32'h81000);
      ahb(1'b1, 32'h04, (k << 6) | 32'h0B);
      wt(2);
      rd_chk("rx_flushed", 32'h08, 32'h81F00, 32'h0);
      wt(2);
      chk("rx_req_drained", 32'h1, rx_dma_request_n[0]);
      rd_chk("ctrl_back", 32'h04, 32'hFF, (k << 6) | 32'h09);
    end
    // Mode 1 transmit fill and flush
    for (int i = 0; i < 15; i++)
      ahb(1'b1, 32'h00, i);
    wt(3);
    chk("tx_req_room", 32'h0, tx_dma_request_n[0]);
    ahb(1'b1, 32'h00, 32'hEE);
    wt(3);
    chk("tx_req_full", 32'h1, tx_dma_request_n[0]);
    rd_chk("tx_count", 32'h08, 32'h1F, 32'h10);
    ahb(1'b1, 32'h04, 32'hCD);
    wt(3);
    rd_chk("tx_flushed", 32'h08, 32'h1F, 32'h0);
    chk("tx_req_flushed", 32'h0, tx_dma_request_n[0]);
    // Time-out below the trigger level
    push(1);
    chk("rx_req_quiet", 32'h1, rx_dma_request_n[0]);
    rx_timeout[0] <= 1'b1;
    wt(1);
    rx_timeout[0] <= 1'b0;
    wt(4);
    chk("rx_req_timeout", 32'h0, rx_dma_request_n[0]);
    ahb(1'b0, 32'h00, 32'h0);
    wt(5);
    chk("rx_req_emptied", 32'h1, rx_dma_request_n[0]);
    // Enable bit low: other bits ignored, FIFOs off
    ahb(1'b1, 32'h04, 32'h08);
    wt(2);
    ahb(1'b1, 32'h00, 32'h01);
    ahb(1'b1, 32'h00, 32'h02);
    wt(3);
    rd_chk("tx_single", 32'h08, 32'h1F, 32'h01);
    rd_chk("ctrl_off", 32'h04, 32'hFF, 32'hC8);
    chk("tx_req_single", 32'h1, tx_dma_request_n);
    end_of_test;
  end
endmodule
